// ---- filt_pkg.sv ----
// Purpose: shared constants and types for the second-stage filter control
// Assumes: 32-bit classic wishbone, 24-bit first-stage samples
// Notes: counts are in decimation periods unless named otherwise
package filt_pkg;
  localparam int DW = 24;
  localparam int HIST_DEPTH = 16;
  localparam int SUM_W = DW + 4;
  localparam int LEN_W = 3;
  localparam int DEC_W = 12;
  localparam int CHAN_W = 3;
  localparam int CNT_W = 7;
  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CHAN_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RESULT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
  // control field positions
  localparam int DEC_LSB = 0;
  localparam int CHOP_BIT = 12;
  localparam int BYP_BIT = 13;
  localparam int FAST_BIT = 14;
  localparam int SINGLE_BIT = 15;
  // interrupt status bit positions
  localparam int IRQ_RESULT_BIT = 0;
  localparam int IRQ_STEP_BIT = 1;
  localparam int IRQ_SETTLED_BIT = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [DEC_W-1:0] DEC_RST = 12'h200;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // timing counts
  localparam logic [3:0] MOD_DIV_LAST = 4'hF;
  localparam logic [CNT_W-1:0] SETTLE_FIR_NOCHOP = 7'h18;
  localparam logic [CNT_W-1:0] SETTLE_FIR_CHOP = 7'h42;
  localparam logic [CNT_W-1:0] SETTLE_BYPASS = 7'h03;
  localparam logic [CNT_W-1:0] SETTLE_FAST_NOCHOP = 7'h03;
  localparam logic [CNT_W-1:0] SETTLE_FAST_CHOP = 7'h06;
  localparam logic [1:0] CHOP_RATIO_LAST = 2'h2;
  localparam logic [3:0] RUN_AVG2 = 4'h2;
  localparam logic [3:0] RUN_AVG4 = 4'h4;
  localparam logic [3:0] RUN_AVG8 = 4'h8;
  localparam logic [3:0] RUN_AVG16 = 4'h6;
  // one percent of full scale on a 24-bit signed code
  localparam logic [DW:0] STEP_THRESH = 25'h00147AE;
  // window lengths as log2
  localparam logic [LEN_W-1:0] LEN_1 = 3'h0;
  localparam logic [LEN_W-1:0] LEN_2 = 3'h1;
  localparam logic [LEN_W-1:0] LEN_4 = 3'h2;
  localparam logic [LEN_W-1:0] LEN_8 = 3'h3;
  localparam logic [LEN_W-1:0] LEN_16 = 3'h4;

  typedef enum logic [2:0] {
    ST_FIR = 3'b000,
    ST_HOLD = 3'b001,
    ST_AVG2 = 3'b010,
    ST_AVG4 = 3'b011,
    ST_AVG8 = 3'b100,
    ST_AVG16 = 3'b101
  } mode_e;

  typedef struct packed {
    logic single;
    logic fast;
    logic bypass;
    logic input_chop_enable;
    logic [DEC_W-1:0] decimation_word;
  } ctrl_s;
endpackage

// ---- sample_history.sv ----
// Purpose: sample history with windowed average of the newest samples
// Assumes: push and window length arrive in the same cycle
// Notes: average leaves a register one cycle after the push
`timescale 1ns/1ps
module sample_history
  import filt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic push_i,
  input wire logic signed [filt_pkg::DW-1:0] data_i,
  input wire logic [filt_pkg::LEN_W-1:0] len_log_i,
  output logic signed [filt_pkg::DW-1:0] older2_o,
  output logic signed [filt_pkg::DW-1:0] avg_o,
  output logic valid_o
);
  logic signed [DW-1:0] hist_reg [HIST_DEPTH];
  logic signed [SUM_W-1:0] sum_next;
  logic signed [SUM_W-1:0] shifted;

  // sample two periods before the incoming one
  assign older2_o = hist_reg[1];

  always_comb
  begin
    sum_next = SUM_W'(data_i);
    for (int i = 1; i < HIST_DEPTH; i++)
    begin
      if (i < (1 << len_log_i))
      begin
        sum_next = sum_next + SUM_W'(hist_reg[i-1]);
      end
    end
  end

  assign shifted = sum_next >>> len_log_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < HIST_DEPTH; i++)
      begin
        hist_reg[i] <= '0;
      end
      avg_o <= '0;
      valid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      valid_o <= push_i;
      if (push_i)
      begin
        hist_reg[0] <= data_i;
        for (int i = 1; i < HIST_DEPTH; i++)
        begin
          hist_reg[i] <= hist_reg[i-1];
        end
        avg_o <= shifted[DW-1:0];
      end
    end
  end
endmodule

// ---- second_stage_filter.sv ----
// Purpose: second-stage filter control, step acceleration and result schedule
// Assumes: first-stage samples come from logic on clk_i
// Notes: registers reached over classic wishbone
`timescale 1ns/1ps
module second_stage_filter
  import filt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic smp_valid_i,
  input wire logic signed [filt_pkg::DW-1:0] smp_data_i,
  output logic [filt_pkg::CHAN_W-1:0] channel_o,
  output logic result_valid_o,
  output logic signed [filt_pkg::DW-1:0] result_o,
  output logic not_steady_flag_o,
  output logic irq_o
);
  import filt_pkg::*;

  ctrl_s ctrl_reg;
  ctrl_s ctrl_next;
  logic [CHAN_W-1:0] chan_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [3:0] mod_cnt_reg;
  logic [DEC_W-1:0] dec_cnt_reg;
  logic [CNT_W-1:0] blank_cnt_reg;
  logic [CNT_W-1:0] settle_val;
  logic [1:0] div_reg;
  logic [3:0] run_cnt_reg;
  logic [3:0] run_cnt_next;
  mode_e mode_reg;
  mode_e mode_next;
  logic not_steady_reg;
  logic not_steady_next;
  logic chg_pend_reg;
  logic run_reg;
  logic emit_d_reg;
  logic signed [DW-1:0] latest_reg;
  logic signed [DW-1:0] older2;
  logic signed [DW-1:0] avg;
  logic hist_valid;
  logic [LEN_W-1:0] len_log;
  logic signed [DW:0] diff;
  logic [DW:0] abs_diff;
  logic step;
  logic fast_act;
  logic mod_tick;
  logic proc_tick;
  logic emit;
  logic bus_req;
  logic wr_stb;
  logic wr_ctrl;
  logic wr_chan;
  logic wr_istat;
  logic wr_imask;
  logic [31:0] rd_data;
  logic [DEC_W-1:0] dec_last;

  // bus decode
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = bus_req && wb_we_i && ce_i;
  assign wr_ctrl = wr_stb && wb_adr_i == CTRL_OFS;
  assign wr_chan = wr_stb && wb_adr_i == CHAN_OFS && wb_sel_i[0];
  assign wr_istat = wr_stb && wb_adr_i == IRQ_STAT_OFS && wb_sel_i[0];
  assign wr_imask = wr_stb && wb_adr_i == IRQ_MASK_OFS && wb_sel_i[0];
  assign ctrl_next = ctrl_s'({wb_sel_i[1] ? wb_dat_i[15:8] : ctrl_reg[15:8],
                             wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_reg[7:0]});

  assign rd_data = (wb_adr_i == CTRL_OFS) ? {16'h0000, ctrl_reg} :
                   (wb_adr_i == CHAN_OFS) ? {29'h0, chan_reg} :
                   (wb_adr_i == STATUS_OFS) ? {30'h0, run_reg, not_steady_reg} :
                   (wb_adr_i == RESULT_OFS) ? {{8{result_o[DW-1]}}, result_o} :
                   (wb_adr_i == IRQ_STAT_OFS) ? {29'h0, irq_stat_reg} :
                   (wb_adr_i == IRQ_MASK_OFS) ? {29'h0, irq_mask_reg} : 32'h0000_0000;

  assign mod_tick = ce_i && mod_cnt_reg == MOD_DIV_LAST;
  assign dec_last = (ctrl_reg.decimation_word == '0) ? '0 : ctrl_reg.decimation_word - 1'b1;
  assign proc_tick = mod_tick && dec_cnt_reg >= dec_last && !wr_chan;

  assign fast_act = ctrl_reg.fast && !ctrl_reg.bypass;

  assign diff = {latest_reg[DW-1], latest_reg} - {older2[DW-1], older2};
  assign abs_diff = diff[DW] ? (~diff + 1'b1) : diff;
  assign step = abs_diff > STEP_THRESH;

  // settling periods after a channel change
  assign settle_val = ctrl_reg.bypass ? SETTLE_BYPASS :
                      ctrl_reg.fast ? (ctrl_reg.input_chop_enable ? SETTLE_FAST_CHOP : SETTLE_FAST_NOCHOP) :
                      (ctrl_reg.input_chop_enable ? SETTLE_FIR_CHOP : SETTLE_FIR_NOCHOP);

  // results only once settled, then every 1 or 3 periods
  assign emit = proc_tick && run_reg && (blank_cnt_reg == 7'h01 || (blank_cnt_reg == '0 && div_reg == '0));

  // acceleration schedule
  always_comb
  begin
    mode_next = mode_reg;
    run_cnt_next = run_cnt_reg;
    not_steady_next = not_steady_reg;
    if (!fast_act)
    begin
      mode_next = ST_FIR;
      not_steady_next = 1'b0;
    end
    else
    begin
      case (mode_reg)
        ST_FIR:
        begin
          mode_next = ST_FIR;
        end
        ST_HOLD:
        begin
          // first non-step sample opens the 2-average run
          mode_next = ST_AVG2;
          run_cnt_next = RUN_AVG2;
        end
        ST_AVG2:
        begin
          if (run_cnt_reg == 4'h1)
          begin
            mode_next = ST_AVG4;
            run_cnt_next = RUN_AVG4;
          end
          else
          begin
            run_cnt_next = run_cnt_reg - 1'b1;
          end
        end
        ST_AVG4:
        begin
          if (run_cnt_reg == 4'h1)
          begin
            mode_next = ST_AVG8;
            run_cnt_next = RUN_AVG8;
          end
          else
          begin
            run_cnt_next = run_cnt_reg - 1'b1;
          end
        end
        ST_AVG8:
        begin
          if (run_cnt_reg == 4'h1)
          begin
            mode_next = ST_AVG16;
            run_cnt_next = RUN_AVG16;
          end
          else
          begin
            run_cnt_next = run_cnt_reg - 1'b1;
          end
        end
        ST_AVG16:
        begin
          if (run_cnt_reg == 4'h1)
          begin
            // back to normal filter clears the flag
            mode_next = ST_FIR;
            not_steady_next = 1'b0;
          end
          else
          begin
            run_cnt_next = run_cnt_reg - 1'b1;
          end
        end
        default:
        begin
          mode_next = ST_FIR;
        end
      endcase
      // step or channel change forces averaging, set wins
      if (step || chg_pend_reg)
      begin
        mode_next = ST_HOLD;
        not_steady_next = 1'b1;
      end
    end
  end

  // window length per state; normal filter window
  assign len_log = (mode_next == ST_HOLD) ? (ctrl_reg.input_chop_enable ? LEN_2 : LEN_1) :
                   (mode_next == ST_AVG2) ? LEN_2 :
                   (mode_next == ST_AVG4) ? LEN_4 :
                   (mode_next == ST_AVG8) ? LEN_8 : LEN_16;

  sample_history u_hist (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(proc_tick),
    .data_i(latest_reg),
    .len_log_i(len_log),
    .older2_o(older2),
    .avg_o(avg),
    .valid_o(hist_valid)
  );

  // interrupt event sources
  assign irq_set[IRQ_RESULT_BIT] = hist_valid && emit_d_reg && ce_i;
  assign irq_set[IRQ_STEP_BIT] = proc_tick && not_steady_next && !not_steady_reg;
  assign irq_set[IRQ_SETTLED_BIT] = proc_tick && !not_steady_next && not_steady_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);
  assign not_steady_flag_o = not_steady_reg;
  assign channel_o = chan_reg;

  // bus slave and registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_reg <= '{single: 1'b0, fast: 1'b0, bypass: 1'b0, input_chop_enable: 1'b0, decimation_word: DEC_RST};
      chan_reg <= CHAN_RST;
      irq_mask_reg <= IRQ_MASK_RST;
      irq_stat_reg <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_data;
      if (wr_ctrl)
      begin
        ctrl_reg <= ctrl_next;
      end
      if (wr_chan)
      begin
        chan_reg <= wb_dat_i[CHAN_W-1:0];
      end
      if (wr_imask)
      begin
        irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
      end
      // new events win over write-one-to-clear
      irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? wb_dat_i[IRQ_W-1:0] : 3'h0)) | irq_set;
    end
  end

  // timing and schedule state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mod_cnt_reg <= '0;
      dec_cnt_reg <= '0;
      blank_cnt_reg <= SETTLE_FIR_NOCHOP;
      div_reg <= '0;
      mode_reg <= ST_FIR;
      run_cnt_reg <= '0;
      not_steady_reg <= 1'b0;
      chg_pend_reg <= 1'b0;
      run_reg <= 1'b1;
      emit_d_reg <= 1'b0;
      latest_reg <= '0;
    end
    else if (ce_i)
    begin
      mod_cnt_reg <= mod_cnt_reg + 1'b1;
      if (smp_valid_i)
      begin
        latest_reg <= smp_data_i;
      end
      emit_d_reg <= emit;
      if (wr_chan)
      begin
        dec_cnt_reg <= '0;
        blank_cnt_reg <= settle_val;
        div_reg <= '0;
        run_reg <= 1'b1;
        chg_pend_reg <= fast_act;
      end
      else
      begin
        if (mod_tick)
        begin
          dec_cnt_reg <= proc_tick ? '0 : dec_cnt_reg + 1'b1;
        end
        if (proc_tick)
        begin
          chg_pend_reg <= 1'b0;
          mode_reg <= mode_next;
          run_cnt_reg <= run_cnt_next;
          not_steady_reg <= not_steady_next;
          if (blank_cnt_reg != '0)
          begin
            blank_cnt_reg <= blank_cnt_reg - 1'b1;
          end
          // one result per period, or per three with chop
          if (emit)
          begin
            div_reg <= ctrl_reg.input_chop_enable ? CHOP_RATIO_LAST : 2'h0;
          end
          else if (div_reg != '0)
          begin
            div_reg <= div_reg - 1'b1;
          end
          // single conversion stops unless still settling
          if (emit && ctrl_reg.single && !(fast_act && not_steady_next))
          begin
            run_reg <= 1'b0;
          end
        end
      end
    end
  end

  // result output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_o <= '0;
      result_valid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      result_valid_o <= hist_valid && emit_d_reg;
      if (hist_valid && emit_d_reg)
      begin
        result_o <= avg;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_step_seen;
    proc_tick && fast_act && step;
  endsequence
  sequence s_enter_hold;
    mode_reg == ST_HOLD && not_steady_reg;
  endsequence

  property p_mod_spacing;
    mod_tick |=> !mod_tick [*8];
  endproperty
  a_mod_spacing: assert property (p_mod_spacing) else $error("modulator ticks too close");

  property p_fast_off;
    proc_tick && !ctrl_reg.fast |=> mode_reg == ST_FIR && !not_steady_reg;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("averaging without acceleration");

  property p_bypass;
    proc_tick && ctrl_reg.bypass |=> mode_reg == ST_FIR;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not suppress averaging");

  property p_step_hold;
    s_step_seen |=> s_enter_hold;
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("step not switched to averaging");

  property p_chan_force;
    proc_tick && fast_act && chg_pend_reg |=> s_enter_hold;
  endproperty
  a_chan_force: assert property (p_chan_force) else $error("channel change not forcing averaging");

  property p_chan_pend;
    wr_chan && fast_act |=> chg_pend_reg;
  endproperty
  a_chan_pend: assert property (p_chan_pend) else $error("channel change not pending");

  property p_hold_len;
    proc_tick && mode_next == ST_HOLD |-> len_log == (ctrl_reg.input_chop_enable ? LEN_2 : LEN_1);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("wrong initial average");

  property p_clear;
    proc_tick && fast_act && mode_reg == ST_AVG16 && run_cnt_reg == 4'h1 && !step && !chg_pend_reg
      |=> mode_reg == ST_FIR && !not_steady_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared on return");

  property p_blank;
    result_valid_o |-> $past(blank_cnt_reg, 2) <= 7'h01;
  endproperty
  a_blank: assert property (p_blank) else $error("result before settling");

  property p_settle_fir;
    wr_chan && !ctrl_reg.bypass && !ctrl_reg.fast && ctrl_reg.input_chop_enable |=> blank_cnt_reg == 7'h42;
  endproperty
  a_settle_fir: assert property (p_settle_fir) else $error("wrong normal settling count");

  property p_settle_fast;
    wr_chan && fast_act && !ctrl_reg.input_chop_enable |=> blank_cnt_reg == 7'h03;
  endproperty
  a_settle_fast: assert property (p_settle_fast) else $error("wrong accelerated settling count");

  property p_single;
    emit && ctrl_reg.single && fast_act && not_steady_next |=> run_reg;
  endproperty
  a_single: assert property (p_single) else $error("single mode stopped while settling");

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus not answered");
endmodule

// ---- first_stage_model.sv ----
// Purpose: first-stage filter output stream feeding the second stage
// Assumes: one sample strobe per modulator tick, sixteen clocks apart
// Notes: data shows the inverse of the sample outside the strobe
`timescale 1ns/1ps
module first_stage_model
  import filt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [filt_pkg::DW-1:0] level_i,
  output logic smp_valid_o,
  output logic signed [filt_pkg::DW-1:0] smp_data_o
);
  logic [3:0] div_reg;
  logic strobe;
  assign strobe = (div_reg == MOD_DIV_LAST);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_reg <= 4'h0;
      smp_valid_o <= 1'b0;
      smp_data_o <= '0;
    end
    else
    begin
      div_reg <= div_reg + 4'h1;
      smp_valid_o <= strobe;
      smp_data_o <= strobe ? level_i : ~level_i;
    end
  end
endmodule

// ---- second_stage_filter_step_settling_bench.sv ----
// Purpose: self-checking bench for second-stage filter control
// Assumes: decimation word 2, one period is 32 clocks
// Notes: monitor queues hold result cycle, value and flag
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (a), (b)); end end
module second_stage_filter_step_settling_bench;
  import filt_pkg::*;
  localparam int DEC = 2;
  localparam int PER = 16 * DEC;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, smp_valid, result_valid_o, not_steady_flag_o, irq_o;
  logic signed [DW-1:0] smp_data, result_o;
  logic signed [DW-1:0] level = 24'sh0;
  logic [CHAN_W-1:0] channel_o;
  logic [CHAN_W-1:0] chan = 3'h0;
  logic [31:0] rng = 32'h5F;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int req_cyc = 0;
  int sz;
  int rq[$];
  logic signed [DW-1:0] vq[$];
  logic fq[$];

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (result_valid_o === 1'b1)
    begin
      rq.push_back(cyc_cnt);
      vq.push_back(result_o);
      fq.push_back(not_steady_flag_o);
    end
  end

  second_stage_filter u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid),
    .smp_data_i(smp_data), .channel_o(channel_o), .result_valid_o(result_valid_o),
    .result_o(result_o), .not_steady_flag_o(not_steady_flag_o), .irq_o(irq_o));
  first_stage_model u_src (.clk_i(clk_i), .rst_i(rst_i), .level_i(level),
    .smp_valid_o(smp_valid), .smp_data_o(smp_data));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      if (n == 0)
        req_cyc = cyc_cnt;
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      error_cnt++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  task automatic clr();
    rq.delete();
    vq.delete();
    fq.delete();
  endtask

  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (rq.size() < n && k < 4000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 4000)
      error_cnt++;
  endtask

  task automatic wait_low();
    int k;
    k = 0;
    while (not_steady_flag_o !== 1'b0 && k < 60 * PER)
    begin
      @(posedge clk_i);
      k++;
    end
    `CHK(not_steady_flag_o, 1'b0)
  endtask

  task automatic run_mode(input logic [3:0] m, input int first_n, input int gap);
    int d;
    wb(1'b1, CTRL_OFS, {16'h0, m, 12'(DEC)});
    chan = chan + 3'h1;
    wb(1'b1, CHAN_OFS, {29'h0, chan});
    d = req_cyc;
    repeat (4) @(posedge clk_i);
    clr();
    wait_res(2);
    `CHK(channel_o, chan)
    `CHK((rq[0] - d > (first_n - 1) * PER) && (rq[0] - d <= first_n * PER + 4), 1'b1)
    `CHK(rq[1] - rq[0], gap * PER)
    `CHK(vq[1], level)
    `CHK(fq[0], m[2] & ~m[1])
    $display("mode %0h done", m);
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(CTRL_OFS, {16'h0, 4'h0, DEC_RST});
    rd_chk(IRQ_MASK_OFS, 32'h0);
    rd_chk(8'h20, 32'h0);
    rng = xs(rng);
    level <= $signed({2'b00, rng[21:0]});
    $display("reset test done");
    run_mode(4'b0000, 24, 1);
    `CHK(irq_o, 1'b0)
    run_mode(4'b0001, 66, 3);
    run_mode(4'b0110, 3, 1);
    run_mode(4'b0111, 3, 3);
    run_mode(4'b0100, 3, 1);
    run_mode(4'b0101, 6, 3);
    wb(1'b1, CTRL_OFS, {16'h0, 4'b0100, 12'(DEC)});
    wait_low();
    wb(1'b1, CTRL_OFS, {16'h0, 4'b1100, 12'(DEC)});
    wb(1'b1, IRQ_MASK_OFS, 32'h7);
    repeat (3 * PER) @(posedge clk_i);
    wb(1'b1, IRQ_STAT_OFS, 32'h7);
    rd_chk(IRQ_STAT_OFS, 32'h0);
    `CHK(irq_o, 1'b0)
    clr();
    wb(1'b1, CHAN_OFS, 32'h6);
    wait_res(1);
    `CHK(fq[0], 1'b1)
    wait_low();
    sz = rq.size();
    `CHK(sz, 19)
    repeat (4 * PER) @(posedge clk_i);
    `CHK(rq.size() - sz, 1)
    foreach (vq[i]) `CHK(vq[i], level)
    foreach (fq[i]) `CHK(fq[i], i < 19)
    rd_chk(STATUS_OFS, 32'h0);
    `CHK(irq_o, 1'b1)
    rd_chk(IRQ_STAT_OFS, 32'h7);
    wb(1'b1, IRQ_STAT_OFS, 32'h7);
    `CHK(irq_o, 1'b0)
    $display("single settle test done");
    wb(1'b1, CTRL_OFS, {16'h0, 4'b0100, 12'(DEC)});
    wb(1'b1, CHAN_OFS, 32'h2);
    repeat (6 * PER) @(posedge clk_i);
    wait_low();
    level <= level + 24'sh08000;
    repeat (4 * PER) @(posedge clk_i);
    `CHK(not_steady_flag_o, 1'b0)
    level <= level + 24'sh20000;
    repeat (4 * PER) @(posedge clk_i);
    `CHK(not_steady_flag_o, 1'b1)
    rd_chk(STATUS_OFS, 32'h3);
    wait_low();
    clr();
    wait_res(1);
    `CHK(vq[0], level)
    rd_chk(RESULT_OFS, {8'h00, level});
    $display("step test done");
    wb(1'b1, CTRL_OFS, {16'h0, 4'b0000, 12'(DEC)});
    repeat (2 * PER) @(posedge clk_i);
    level <= level + 24'sh20000;
    repeat (4 * PER) @(posedge clk_i);
    `CHK(not_steady_flag_o, 1'b0)
    $display("fast off test done");
    finish_test();
  end
endmodule
